// >>> verilog/ssp_port.sv
// Purpose: Synchronous serial port, master or slave, with Wishbone registers.
// Assumes: 100 MHz i_mclk; serial pins are asynchronous and are synchronised.
// Notes:   Pins are split into value and output enable; enable high drives.
module ssp_port #(
    parameter bit SIO_EN    = 1'b1,
    parameter bit WRITE_COLLISION_FLAG_EN   = 1'b1,
    parameter bit SELECT_LINE_ENABLE_EN   = 1'b1,
    parameter bit CLOCK_EDGE_POLARITY_RISE = 1'b1,
    parameter bit VEC_AT_14 = 1'b0
) (
    input  wire logic        i_mclk,
    input  wire logic        i_resetn,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_sck,
    output logic             o_sck,
    output logic             o_sck_oe,
    input  wire logic        i_serial_in_pin,
    output logic             o_serial_out_pin,
    output logic             o_serial_out_pin_oe,
    input  wire logic        i_select_pin_n,
    output logic             o_select_pin_n,
    output logic             o_select_pin_n_oe,
    output logic             o_irq_vec08,
    output logic             o_irq_vec14
);

    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        ssp_pkg::ssp_state_t state;
        logic [1:0]          mode;
        logic                cks;
        logic                en;
        logic                msb;
        logic                select_line_enable;
        logic                write_collision_flag;
        logic                transfer_done_flag;
        logic [7:0]          shift;
        logic [7:0]          rx;
        logic [3:0]          bitcnt;
        logic [4:0]          divcnt;
        logic                phase;
        logic                sck_o;
        logic                sel_o;
        logic                serial_out_pin;
        logic                sck_prev;
        logic                ack;
        logic [7:0]          rdat;
    } ssp_regs_t;

    ssp_regs_t r;
    ssp_regs_t n;

    logic [2:0] pins_s;
    logic       sck_s;
    logic       sdi_s;
    logic       sel_s;
    logic       idle_lvl;
    logic       select_line_enable_eff;
    logic       en_eff;
    logic       master;
    logic       busy;
    logic       acc;
    logic       wr;
    logic       tick;
    logic       act_edge;
    logic [2:0] hl;
    logic [5:0] lim6;

    // =====================================================================
    // Helpers
    // =====================================================================

    // Bit presented on the data output for a given buffer and order.
    function automatic logic out_bit(input logic [7:0] sh, input logic msb);
        out_bit = msb ? sh[7] : sh[0];
    endfunction

    // Shift one received bit into the buffer in the chosen order.
    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic d,
                                            input logic msb);
        shift_in = msb ? {sh[6:0], d} : {d, sh[7:1]};
    endfunction

    // Exponent of the half period in system clocks for a master mode.
    function automatic logic [2:0] half_log(input logic cks, input logic [1:0] mode);
        logic [2:0] l;
        l = cks ? 3'h0 : ssp_pkg::LOG_CKS0;
        case (mode)
            ssp_pkg::MODE_M4: begin
                l = l + ssp_pkg::LOG_M4;
            end
            ssp_pkg::MODE_M16: begin
                l = l + ssp_pkg::LOG_M16;
            end
            default: begin
            end
        endcase
        half_log = (l == 3'h0) ? 3'h0 : l - 3'h1;
    endfunction

    // =====================================================================
    // Pin synchronisers
    // =====================================================================
    ssp_sync #(
        .W (3)
    ) u_sync (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_async  ({i_sck, i_serial_in_pin, i_select_pin_n}),
        .o_sync   (pins_s)
    );

    assign sck_s = pins_s[2];
    assign sdi_s = pins_s[1];
    assign sel_s = pins_s[0];

    // =====================================================================
    // Derived terms
    // =====================================================================

    assign idle_lvl = CLOCK_EDGE_POLARITY_RISE;
    assign act_edge = CLOCK_EDGE_POLARITY_RISE ? (sck_s & ~r.sck_prev) : (~sck_s & r.sck_prev);
    assign select_line_enable_eff = SELECT_LINE_ENABLE_EN & r.select_line_enable;
    assign en_eff   = SIO_EN & r.en;
    assign master   = r.mode != ssp_pkg::MODE_SLAVE;
    assign busy     = (r.state != ssp_pkg::SSP_IDLE) | (r.bitcnt != 4'h0);
    assign hl       = half_log(r.cks, r.mode);
    assign lim6     = (6'h01 << hl) - 6'h01;
    assign tick     = r.divcnt == lim6[4:0];
    assign acc      = i_wb_cyc & i_wb_stb;
    assign wr       = acc & r.ack & i_wb_we & i_wb_sel[0];

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb begin
        n          = r;
        n.sck_prev = sck_s;

        // Bus answer: ack one cycle after the request, read data with it.
        n.ack = acc & ~r.ack;
        if (acc & ~r.ack & ~i_wb_we) begin
            case (i_wb_adr)
                ssp_pkg::ADR_CTRL: begin
                    n.rdat = {r.cks, r.mode, r.en, r.msb, select_line_enable_eff,
                              r.write_collision_flag & WRITE_COLLISION_FLAG_EN, r.transfer_done_flag};
                end
                ssp_pkg::ADR_DATA: begin
                    n.rdat = r.rx;
                end
                default: begin
                    n.rdat = 8'h00;
                end
            endcase
        end

        // Control write; flags clear when written with zero, or when the write clears the enable.
        if (wr && (i_wb_adr == ssp_pkg::ADR_CTRL)) begin
            n.cks  = i_wb_dat[ssp_pkg::CB_CKS];
            n.mode = i_wb_dat[ssp_pkg::CB_MODE +: 2];
            n.en   = i_wb_dat[ssp_pkg::CB_EN];
            n.msb  = i_wb_dat[ssp_pkg::CB_MSB];
            n.select_line_enable = i_wb_dat[ssp_pkg::CB_SELECT_LINE_ENABLE];
            if (!i_wb_dat[ssp_pkg::CB_WRITE_COLLISION_FLAG]) begin
                n.write_collision_flag = 1'b0;
            end
            if (!i_wb_dat[ssp_pkg::CB_TRF]) begin
                n.transfer_done_flag = 1'b0;
            end
        end

        // Data write when enabled: refused while shifting, else loads the buffer.
        if (wr && (i_wb_adr == ssp_pkg::ADR_DATA) && en_eff) begin
            if (busy) begin
                n.write_collision_flag = WRITE_COLLISION_FLAG_EN;
            end else begin
                n.shift = i_wb_dat[7:0];
                n.serial_out_pin   = out_bit(i_wb_dat[7:0], r.msb);
                n.transfer_done_flag   = 1'b0;
                if (master) begin
                    n.divcnt = 5'h00;
                    n.phase  = 1'b0;
                    if (select_line_enable_eff) begin
                        n.sel_o = 1'b0;
                        n.state = ssp_pkg::SSP_SETUP;
                    end else begin
                        n.state = ssp_pkg::SSP_RUN;
                    end
                end
            end
        end

        // Master sequencer; no halt gating.
        if (r.state != ssp_pkg::SSP_IDLE) begin
            n.divcnt = tick ? 5'h00 : r.divcnt + 5'h01;
        end
        case (r.state)
            ssp_pkg::SSP_SETUP: begin
                if (tick) begin
                    n.state = ssp_pkg::SSP_RUN;
                end
            end
            ssp_pkg::SSP_RUN: begin
                if (tick && !r.phase) begin
                    n.sck_o = ~idle_lvl;
                    n.phase = 1'b1;
                end else if (tick) begin
                    n.sck_o  = idle_lvl;
                    n.phase  = 1'b0;
                    n.shift  = shift_in(r.shift, sdi_s, r.msb);
                    n.serial_out_pin    = out_bit(n.shift, r.msb);
                    n.bitcnt = r.bitcnt + 4'h1;
                    if (r.bitcnt == ssp_pkg::BITS_LAST) begin
                        n.state  = ssp_pkg::SSP_IDLE;
                        n.bitcnt = 4'h0;
                        n.rx     = n.shift;
                        n.transfer_done_flag    = 1'b1;
                        n.sel_o  = 1'b1;
                        n.serial_out_pin    = 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase

        // Slave engine driven by the partner's clock.
        if (!master && en_eff) begin
            if (select_line_enable_eff && sel_s) begin
                n.bitcnt = 4'h0;
            end else if (act_edge) begin
                n.shift  = shift_in(r.shift, sdi_s, r.msb);
                n.serial_out_pin    = out_bit(n.shift, r.msb);
                n.bitcnt = r.bitcnt + 4'h1;
                if (r.bitcnt == ssp_pkg::BITS_LAST) begin
                    n.bitcnt = 4'h0;
                    n.rx     = n.shift;
                    n.transfer_done_flag    = 1'b1;
                    n.serial_out_pin    = 1'b1;
                end
            end
        end

        // Disabled port returns to standby values.
        if (!(SIO_EN && n.en)) begin
            n.state  = ssp_pkg::SSP_IDLE;
            n.bitcnt = 4'h0;
            n.write_collision_flag   = 1'b0;
            n.transfer_done_flag    = 1'b0;
            n.serial_out_pin    = 1'b1;
            n.sck_o  = idle_lvl;
            n.sel_o  = 1'b1;
            n.phase  = 1'b0;
        end
    end

    // =====================================================================
    // State register
    // =====================================================================
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    assign o_wb_dat = {24'h000000, r.rdat};
    assign o_wb_ack = r.ack;

    assign o_sck    = r.sck_o;
    assign o_sck_oe = en_eff & master;

    assign o_serial_out_pin    = r.serial_out_pin;
    assign o_serial_out_pin_oe = en_eff;

    assign o_select_pin_n    = r.sel_o;
    assign o_select_pin_n_oe = en_eff & master & select_line_enable_eff;

    assign o_irq_vec08 = r.transfer_done_flag & ~VEC_AT_14;
    assign o_irq_vec14 = r.transfer_done_flag & VEC_AT_14;

endmodule // ssp_port

// >>> verilog/ssp_pkg.sv
// Purpose: Shared constants and types for the synchronous serial port.
// Assumes: Registers sit on a 32-bit classic Wishbone bus, one word each.
// Notes:   Only byte lane 0 of each register word carries data.
package ssp_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_DATA = 8'h04;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // =====================================================================
    // Control register fields
    // =====================================================================
    localparam int CB_TRF  = 0;
    localparam int CB_WRITE_COLLISION_FLAG = 1;
    localparam int CB_SELECT_LINE_ENABLE = 2;
    localparam int CB_MSB  = 3;
    localparam int CB_EN   = 4;
    localparam int CB_MODE = 5;
    localparam int CB_CKS  = 7;

    // =====================================================================
    // Mode field codes and divider exponents
    // =====================================================================
    localparam logic [1:0] MODE_M1    = 2'h0;
    localparam logic [1:0] MODE_M4    = 2'h1;
    localparam logic [1:0] MODE_M16   = 2'h2;
    localparam logic [1:0] MODE_SLAVE = 2'h3;
    localparam logic [2:0] LOG_CKS0   = 3'h2;
    localparam logic [2:0] LOG_M4     = 3'h2;
    localparam logic [2:0] LOG_M16    = 3'h4;
    localparam logic [3:0] BITS_LAST  = 4'h7;

    // =====================================================================
    // Master sequencer states
    // =====================================================================
    typedef enum logic [1:0] {
        SSP_IDLE,
        SSP_SETUP,
        SSP_RUN
    } ssp_state_t;

endpackage

// >>> verilog/ssp_sync.sv
// Purpose: Two flip-flop synchroniser for pins from outside the clock domain.
// Assumes: Inputs are asynchronous levels.
// Notes:   The first stage feeds only the second stage.
module ssp_sync #(
    parameter int W = 1
) (
    input  wire logic         i_mclk,
    input  wire logic         i_resetn,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } ssp_sync_t;

    ssp_sync_t r;
    ssp_sync_t n;

    // Shift the pin levels through two stages.
    always_comb begin
        n      = r;
        n.meta = i_async;
        n.sync = r.meta;
    end

    // Register the stages.
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign o_sync = r.sync;

endmodule // ssp_sync

// >>> dv/ssp_port_assertions.sv
// Purpose: Concurrent checks on the serial port's bus answers and pins.
// Assumes: One domain on i_mclk with an active-low asynchronous reset.
// Notes:   Bound into every ssp_port instance.
module ssp_port_assertions #(
    parameter bit CLOCK_EDGE_POLARITY_RISE = 1'b1,
    parameter bit VEC_AT_14 = 1'b0
) (
    input wire logic        i_mclk,
    input wire logic        i_resetn,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        o_sck,
    input wire logic        o_sck_oe,
    input wire logic        o_serial_out_pin,
    input wire logic        o_serial_out_pin_oe,
    input wire logic        o_select_pin_n,
    input wire logic        o_select_pin_n_oe,
    input wire logic        o_irq_vec08,
    input wire logic        o_irq_vec14
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Properties
    // ==========
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held too long");
    a_ack_answers: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("request not answered");
    a_unmapped_zero: assert property (o_wb_ack && !i_wb_we
        && i_wb_adr != ssp_pkg::ADR_CTRL && i_wb_adr != ssp_pkg::ADR_DATA |-> o_wb_dat == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
        else $error("upper read bits set");
    a_irq_route: assert property (VEC_AT_14 ? !o_irq_vec08 : !o_irq_vec14)
        else $error("interrupt on wrong vector");
    a_irq_holds: assert property ((o_irq_vec08 || o_irq_vec14)
        && !(o_wb_ack && i_wb_we) |=> (o_irq_vec08 || o_irq_vec14))
        else $error("done flag dropped alone");
    a_idle_levels: assert property (o_select_pin_n_oe && o_select_pin_n
        |-> o_serial_out_pin && o_sck_oe && o_sck == CLOCK_EDGE_POLARITY_RISE)
        else $error("idle pin levels wrong");
    a_sel_leads: assert property ($fell(o_select_pin_n) && o_select_pin_n_oe
        |-> o_sck == CLOCK_EDGE_POLARITY_RISE ##1 o_sck == CLOCK_EDGE_POLARITY_RISE)
        else $error("clock moved with select");
    a_pins_off: assert property (!o_serial_out_pin_oe |-> !o_sck_oe && !o_select_pin_n_oe)
        else $error("pin driven while off");
    c_master_done: cover property (o_sck_oe && $rose(o_irq_vec08));
    c_slave_done: cover property (!o_sck_oe && o_serial_out_pin_oe && $rose(o_irq_vec08));
    c_sel_frame: cover property (o_select_pin_n_oe && $fell(o_select_pin_n));
endmodule // ssp_port_assertions

bind ssp_port ssp_port_assertions #(.CLOCK_EDGE_POLARITY_RISE(CLOCK_EDGE_POLARITY_RISE), .VEC_AT_14(VEC_AT_14)) chk (
    .i_mclk, .i_resetn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack,
    .o_sck, .o_sck_oe, .o_serial_out_pin, .o_serial_out_pin_oe, .o_select_pin_n,
    .o_select_pin_n_oe, .o_irq_vec08, .o_irq_vec14);

// >>> dv/ssp_far_end.sv
// Purpose: Behavioural far-side serial device, as slave or clock master.
// Assumes: The clock idles high; data is taken on its rising edge as master and on its falling edge as slave.
// Notes:   As master it runs a 125 ns clock, only inside frames.
module ssp_far_end (
    input  wire logic       i_sck,
    input  wire logic       i_sdo,
    input  wire logic       i_msb,
    output logic            o_sdi,
    output logic            o_sck,
    output logic            o_sel_n,
    output logic      [7:0] o_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx_q;
    int         n;
    bit         drive;

    // Picks outgoing bit k in the chosen order.
    function automatic logic pick(input int k);
        return i_msb ? tx_q[7-k] : tx_q[k];
    endfunction

    // Shifts one received bit into the byte in the chosen order.
    function automatic logic [7:0] grab(input logic [7:0] r, input logic b);
        return i_msb ? {r[6:0], b} : {b, r[7:1]};
    endfunction

    // Lines rest at their idle levels.
    initial begin
        o_sck = 1'b1;
        o_sel_n = 1'b1;
        o_rx = 8'h00;
        tx_q = 8'h00;
        o_sdi = 1'b0;
        n = 0;
        drive = 1'b0;
    end

    // Loads a byte and shows its first bit at once.
    task automatic arm(input logic [7:0] b);
        tx_q = b;
        n = 0;
        o_sdi = pick(0);
    endtask

    // one byte each way
    // As slave, the master's data is taken on the leading edge, where it is stable.
    always @(negedge i_sck) begin
        if (!drive) begin
            o_rx = grab(o_rx, i_sdo);
        end
    end

    // As slave, the next bit appears once the master has sampled.
    always @(posedge i_sck) begin
        if (!drive) begin
            n = (n + 1) % 8;
            o_sdi = pick(n);
        end
    end

    // eight clock periods
    // As master, select is optional so that a frame without it can be sent.
    task automatic frame(input logic use_sel);
        drive = 1'b1;
        o_sel_n = !use_sel;
        #125;
        for (int k = 0; k < 8; k++) begin
            o_sck = 1'b0;
            o_sdi = pick(k);
            #62.5;
            o_sck = 1'b1;
            o_rx = grab(o_rx, i_sdo);
            #62.5;
        end
        o_sel_n = 1'b1;
        drive = 1'b0;
    endtask
endmodule // ssp_far_end

// >>> dv/test_sync_serial_master_slave_port.sv
// Purpose: Self-checking bench for the serial port as master and as slave.
// Assumes: Default build options: clock idles high, vector 08H.
// Notes:   The far side is ssp_far_end; the port's data output line has a pull-up.
module test_sync_serial_master_slave_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_mclk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_rdat;
    logic        wb_ack, sck, sck_oe, serial_out_pin, sdo_oe, sel_n, sel_oe, irq08;
    logic        far_sdi, far_sck, far_sel_n, sck_w, sel_w, sdo_w;
    logic        far_msb = 1'b1;
    logic [7:0]  far_rx, v;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    // Clock, and wires resolved from the port's enables.
    always #5 i_mclk = ~i_mclk;
    assign sck_w = sck_oe ? sck : far_sck;
    assign sel_w = sel_oe ? sel_n : far_sel_n;
    assign sdo_w = sdo_oe ? serial_out_pin : 1'b1;

    ssp_port uut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
        .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(4'hf), .i_wb_dat(wb_dat),
        .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .i_sck(sck_w), .o_sck(sck), .o_sck_oe(sck_oe),
        .i_serial_in_pin(far_sdi), .o_serial_out_pin(serial_out_pin), .o_serial_out_pin_oe(sdo_oe),
        .i_select_pin_n(sel_w), .o_select_pin_n(sel_n), .o_select_pin_n_oe(sel_oe),
        .o_irq_vec08(irq08), .o_irq_vec14());
    ssp_far_end far (.i_sck(sck_w), .i_sdo(sdo_w), .i_msb(far_msb), .o_sdi(far_sdi),
        .o_sck(far_sck), .o_sel_n(far_sel_n), .o_rx(far_rx));

    // Prints the counts and the verdict, then stops.
    task automatic close_out();
        $display("compared %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // One classic Wishbone cycle; read data lands in v.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
        int t;
        t = 0;
        @(posedge i_mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= {24'h0, wd};
        do begin
            @(posedge i_mclk);
            t++;
        end while (wb_ack !== 1'b1 && t < 20);
        v = wb_rdat[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        check({7'h0, wb_ack}, 8'h01);
    endtask

    // Reads a register and compares it.
    task automatic expect_reg(input logic [7:0] adr, input logic [7:0] exp);
        wb(1'b0, adr, 8'h00);
        check(v, exp);
    endtask

    // Waits, bounded, for the done interrupt.
    task automatic wait_done();
        for (int t = 0; t < 3000 && irq08 !== 1'b1; t++) begin
            @(posedge i_mclk);
        end
        check({7'h0, irq08}, 8'h01);
    endtask

    // Master byte with a refused second load in flight.
    task automatic master_xfer(input logic [7:0] ctrl, input logic [7:0] tx, input logic [7:0] ftx);
        far_msb = ctrl[3];
        wb(1'b1, ssp_pkg::ADR_CTRL, ctrl & 8'hef);
        wb(1'b1, ssp_pkg::ADR_CTRL, ctrl);
        expect_reg(ssp_pkg::ADR_CTRL, ctrl);
        check({2'h0, sck_oe, sck, sdo_oe, serial_out_pin, sel_oe, sel_n | ~sel_oe}, {6'h0f, ctrl[2], 1'b1});
        far.arm(ftx);
        wb(1'b1, ssp_pkg::ADR_DATA, tx);
        wb(1'b1, ssp_pkg::ADR_DATA, ~tx);
        expect_reg(ssp_pkg::ADR_CTRL, ctrl | 8'h02);
        wait_done();
        expect_reg(ssp_pkg::ADR_DATA, ftx);
        check(far_rx, tx);
        expect_reg(ssp_pkg::ADR_CTRL, ctrl | 8'h03);
        wb(1'b1, ssp_pkg::ADR_CTRL, ctrl);
        expect_reg(ssp_pkg::ADR_CTRL, ctrl);
    endtask

    // Cuts a hang short.
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end

    // Reset, master in three setups, slave with and without select, then disable.
    initial begin
        repeat (8) @(posedge i_mclk);
        i_resetn <= 1'b1;
        expect_reg(ssp_pkg::ADR_CTRL, ssp_pkg::CTRL_RST);
        expect_reg(ssp_pkg::ADR_DATA, ssp_pkg::DATA_RST);
        check({5'h0, sck_oe, sdo_oe, sel_oe}, 8'h00);
        wb(1'b1, 8'h08, 8'hff);
        expect_reg(8'h08, 8'h00);
        master_xfer(8'hdc, 8'h96, 8'h3c);
        master_xfer(8'h30, 8'h96, 8'h2d);
        master_xfer(8'h14, 8'h69, 8'he1);
        wb(1'b1, ssp_pkg::ADR_CTRL, 8'h6c);
        wb(1'b1, ssp_pkg::ADR_CTRL, 8'h7c);
        wb(1'b1, ssp_pkg::ADR_DATA, 8'h5a);
        far_msb = 1'b1;
        far.arm(8'hc3);
        far.frame(1'b0);
        repeat (5) @(posedge i_mclk);
        expect_reg(ssp_pkg::ADR_CTRL, 8'h7c);
        far.arm(8'hc3);
        far.frame(1'b1);
        wait_done();
        expect_reg(ssp_pkg::ADR_DATA, 8'hc3);
        check(far_rx, 8'h5a);
        wb(1'b1, ssp_pkg::ADR_CTRL, 8'h0f);
        expect_reg(ssp_pkg::ADR_CTRL, 8'h0c);
        check({5'h0, sck_oe, sdo_oe, sel_oe}, 8'h00);
        close_out();
    end
endmodule // test_sync_serial_master_slave_port
